// ### tb/hmc_cfg_header_sva.sv
`timescale 1ns/1ps
module hmc_cfg_header_sva (
  input wire logic clk_sys_in, rst_in, cfg_rd_in, cfg_wr_in, cfg_ack_out,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic mmio_req_in, mmio_accept_out, mmio_refuse_out,
  input wire logic irq_pending_in, msi_out, line_irq_out, dma_req_in,
  input wire logic window_req_in, dma_run_out, dma_idle_out, uma_req_out,
  input wire logic fw_bus_master_msg_en_in, fw_msg_ack_in,
  input wire logic engine_msg_req_out,
  input wire logic [15:0] firmware_mirror_of_command_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire logic [15:0] mirror = firmware_mirror_of_command_out;
  property p_msi; msi_out |-> mirror[2]; endproperty
  a_msi: assert property (p_msi) else $error("msi while off");
  property p_dma; dma_idle_out != dma_run_out &&
    (!dma_run_out || $past(dma_req_in)); endproperty
  a_dma: assert property (p_dma) else $error("dma state");
  property p_dma_off; dma_run_out |=> mirror[2]; endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma while off");
  property p_win; !$past(rst_in) |-> uma_req_out == $past(window_req_in);
  endproperty
  a_win: assert property (p_win) else $error("window lost");
  property p_mmio; mmio_req_in |=> mmio_accept_out == mirror[1] &&
    mmio_refuse_out == !mirror[1]; endproperty
  a_mmio: assert property (p_mmio) else $error("mmio decode");
  property p_ro; (mirror & 16'hfbf9) == 16'h0000; endproperty
  a_ro: assert property (p_ro) else $error("command ro bit");
  property p_ack; cfg_rd_in || cfg_wr_in |=> cfg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_sts; cfg_ack_out && $past(cfg_rd_in) && $past(cfg_addr_in) ==
    8'h04 |-> cfg_rdata_out ==
    {11'h000, 1'b1, cfg_rdata_out[19], 3'h0, mirror};
  endproperty
  a_sts: assert property (p_sts) else $error("status");
  property p_line; !$past(rst_in) && !$past(rst_in, 2) &&
    !$past(rst_in, 3) |->
    line_irq_out == ($past(irq_pending_in, 3) && !mirror[10]);
  endproperty
  a_line: assert property (p_line) else $error("line irq");
  property p_eng; $past(fw_bus_master_msg_en_in) && $changed(mirror[2])
    |-> ##[0:3] engine_msg_req_out; endproperty
  a_eng: assert property (p_eng) else $error("engine msg");
  property p_eack; engine_msg_req_out && fw_msg_ack_in |=>
    !engine_msg_req_out; endproperty
  a_eack: assert property (p_eack) else $error("engine ack");
endmodule : hmc_cfg_header_sva
bind hmc_cfg_header hmc_cfg_header_sva u_sva (.*);

// ### tb/hmc_host_model.sv
`timescale 1ns/1ps
module hmc_host_model (
  // Clock and answer
  input wire logic clk_sys_in,
  input wire logic cfg_ack_in,
  input wire logic [31:0] cfg_rdata_in,
  // Request
  output logic cfg_rd_out,
  output logic cfg_wr_out,
  output logic [7:0] cfg_addr_out,
  output logic [3:0] cfg_be_out,
  output logic [31:0] cfg_wdata_out
);
  initial begin
    {cfg_rd_out, cfg_wr_out, cfg_addr_out} = 10'h000;
    {cfg_be_out, cfg_wdata_out} = 36'h0;
  end
  // Strobe is a one-cycle pulse; answer taken at the next edge
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    {cfg_addr_out, cfg_be_out, cfg_wdata_out} = {a, 4'hf, d};
    {cfg_rd_out, cfg_wr_out} = {!wr, wr};
    @(posedge clk_sys_in) #1;
    {cfg_rd_out, cfg_wr_out} = 2'b00;
    @(posedge clk_sys_in);
    q = cfg_ack_in ? cfg_rdata_in : 32'hdead_beef;
    #1;
  endtask : xfer
endmodule : hmc_host_model

// ### tb/test_hmc_cfg_header.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t wrong value", $time); end end
module test_hmc_cfg_header;
  logic clk_sys_in = 0, rst_in = 1, mmio_req_in = 0, irq_pending_in = 0;
  logic msi_req_in = 0, dma_req_in = 0, window_req_in = 0;
  logic fw_bus_master_msg_en_in = 1, fw_msg_ack_in = 0;
  logic cfg_rd_in, cfg_wr_in, cfg_ack_out, mmio_accept_out, mmio_refuse_out;
  logic msi_out, line_irq_out, dma_run_out, dma_idle_out, uma_req_out;
  logic engine_msg_req_out;
  logic [7:0] cfg_addr_in;
  logic [3:0] cfg_be_in;
  logic [31:0] cfg_wdata_in, cfg_rdata_out, q;
  logic [15:0] firmware_mirror_of_command_out;
  int errors = 0, tests_run = 0, cycles = 0;
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  hmc_cfg_header DUT (.*);
  hmc_host_model HOST (.clk_sys_in, .cfg_ack_in(cfg_ack_out),
    .cfg_rdata_in(cfg_rdata_out), .cfg_rd_out(cfg_rd_in),
    .cfg_wr_out(cfg_wr_in), .cfg_addr_out(cfg_addr_in),
    .cfg_be_out(cfg_be_in), .cfg_wdata_out(cfg_wdata_in));
  task automatic give_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step
  task automatic t_reset_values;
    HOST.xfer(1'b0, 8'h04, 32'h0, q);
    `CHK(q, 32'h0010_0000)
    HOST.xfer(1'b0, 8'h08, 32'h0, q);
    `CHK(q, {24'h000000, hmc_pkg::STEPPING})
    HOST.xfer(1'b0, 8'h40, 32'h0, q);
    `CHK(q, 32'h0)
  endtask : t_reset_values
  task automatic t_command;
    HOST.xfer(1'b1, 8'h04, 32'hffff_ffff, q);
    HOST.xfer(1'b0, 8'h04, 32'h0, q);
    `CHK(q, 32'h0010_0406)
    {msi_req_in, dma_req_in, window_req_in, mmio_req_in} = 4'hf;
    step(2);
    `CHK({msi_out, dma_run_out, uma_req_out, mmio_accept_out}, 4'hf)
    `CHK(firmware_mirror_of_command_out, 16'h0406)
    `CHK(engine_msg_req_out, 1'b1)
    fw_msg_ack_in = 1;
    step(1);
    fw_msg_ack_in = 0;
    step(1);
    `CHK(engine_msg_req_out, 1'b0)
    HOST.xfer(1'b1, 8'h04, 32'h0, q);
    step(2);
    `CHK({msi_out, dma_idle_out, uma_req_out, mmio_refuse_out}, 4'h7)
    `CHK(firmware_mirror_of_command_out, 16'h0000)
  endtask : t_command
  task automatic t_irq;
    irq_pending_in = 1;
    step(4);
    HOST.xfer(1'b0, 8'h04, 32'h0, q);
    `CHK({q[19], line_irq_out}, 2'b11)
    HOST.xfer(1'b1, 8'h04, 32'h0404, q);
    step(2);
    `CHK({line_irq_out, msi_out}, 2'b01)
    irq_pending_in = 0;
    step(4);
    HOST.xfer(1'b0, 8'h04, 32'h0, q);
    `CHK(q, 32'h0010_0404)
    // A change seen while busy is kept and sent after the ack
    fw_msg_ack_in = 1;
    step(1);
    fw_msg_ack_in = 0;
    step(3);
    `CHK(engine_msg_req_out, 1'b1)
    fw_msg_ack_in = 1;
    step(1);
    fw_msg_ack_in = 0;
    fw_bus_master_msg_en_in = 0;
    HOST.xfer(1'b1, 8'h04, 32'h0, q);
    step(2);
    `CHK({engine_msg_req_out, firmware_mirror_of_command_out}, 17'h0)
  endtask : t_irq
  task automatic t_mid_reset;
    HOST.xfer(1'b1, 8'h04, 32'h0406, q);
    rst_in = 1;
    step(2);
    rst_in = 0;
    HOST.xfer(1'b0, 8'h04, 32'h0, q);
    `CHK(q, 32'h0010_0000)
    `CHK({msi_out, dma_run_out, dma_idle_out}, 3'b001)
  endtask : t_mid_reset
  initial begin
    repeat (2) @(posedge clk_sys_in);
    #1;
    rst_in = 0;
    t_reset_values();
    t_command();
    t_irq();
    t_mid_reset();
    give_verdict();
  end
endmodule : test_hmc_cfg_header

// ### verilog/hmc_cfg_header.sv
`timescale 1ns/1ps
// How it works
// - Command bit 2 enables bus mastering, resets zero; zero blocks host MSI.
// - Clearing bus mastering halts master activity and idles every DMA engine.
// - Bus master bit is mirrored to firmware; a change may message the engine.
// - Window reads and writes to engine memory continue with mastering off.
// - Command bit 1 enables memory space, resets zero; zero refuses host MMIO.
// - Command bits 9 to 3 and bit 0 are read-only zero.
// - Status bits 15 to 11, 8, 7 and 5 read zero.
// - Status bits 10 to 9 read constant zero-zero.
// - Status bit 4 always reads one: capability list present.
// - Status bit 3 reads one while the synchronised interrupt is pending, even with line interrupts disabled.
// - Byte 8h reports the eight-bit stepping code.
// - Bytes 9h to Bh hold a zero class code in three fields.
// - Command bit 10 suppresses line interrupts but not MSI.
module hmc_cfg_header (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Host configuration access, byte addressed
  input wire logic cfg_rd_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  // Host memory-mapped access request
  input wire logic mmio_req_in,
  output logic mmio_accept_out,
  output logic mmio_refuse_out,
  // Interrupt and MSI sources
  input wire logic irq_pending_in,
  input wire logic msi_req_in,
  output logic msi_out,
  output logic line_irq_out,
  // DMA and window traffic
  input wire logic dma_req_in,
  input wire logic window_req_in,
  output logic dma_run_out,
  output logic dma_idle_out,
  output logic uma_req_out,
  // Firmware side
  input wire logic fw_bus_master_msg_en_in,
  input wire logic fw_msg_ack_in,
  output logic [15:0] firmware_mirror_of_command_out,
  output logic engine_msg_req_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic bus_master_enable;
  logic memory_space_enable;
  logic line_interrupt_disable;
  logic next_bus_master;
  logic next_mem_space;
  logic next_line_irq_off;
  logic irq_sync;
  logic bus_master_prev;
  logic bus_master_change;
  logic [15:0] command_control;
  logic [15:0] device_status_flags;
  logic [7:0] stepping_code;
  logic [23:0] device_class_code;
  logic [31:0] next_rdata;
  logic [15:0] command_wmask;
  logic [15:0] command_wval;
  logic next_ack;
  logic next_mmio_accept;
  logic next_mmio_refuse;
  logic next_msi;
  logic next_line_irq;
  logic next_dma_run;
  logic next_dma_idle;
  logic next_uma_req;
  logic [15:0] next_mirror;

  hmc_sync u_irq_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .d_in(irq_pending_in),
    .q_out(irq_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register views
  always_comb begin
    command_control = 16'h0000;
    command_control[hmc_pkg::BUS_MASTER_BIT] = bus_master_enable;
    command_control[hmc_pkg::MEM_SPACE_BIT] = memory_space_enable;
    command_control[hmc_pkg::LINE_OFF_BIT] = line_interrupt_disable;
    device_status_flags = hmc_pkg::STATUS_CONST;
    device_status_flags[hmc_pkg::IRQ_STATUS_BIT] = irq_sync;
    stepping_code = hmc_pkg::STEPPING;
    device_class_code = hmc_pkg::CLASS_CODE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command writes, only writable bits change
  always_comb begin
    command_wmask = 16'h0000;
    command_wval = cfg_wdata_in[15:0];
    if (cfg_wr_in && cfg_addr_in == hmc_pkg::COMMAND_OFFSET) begin
      command_wmask[7:0] = {8{cfg_be_in[0]}};
      command_wmask[15:8] = {8{cfg_be_in[1]}};
    end
    command_wmask = command_wmask & hmc_pkg::COMMAND_WMASK;
    next_bus_master = command_wmask[hmc_pkg::BUS_MASTER_BIT] ?
      command_wval[hmc_pkg::BUS_MASTER_BIT] : bus_master_enable;
    next_mem_space = command_wmask[hmc_pkg::MEM_SPACE_BIT] ?
      command_wval[hmc_pkg::MEM_SPACE_BIT] : memory_space_enable;
    next_line_irq_off = command_wmask[hmc_pkg::LINE_OFF_BIT] ?
      command_wval[hmc_pkg::LINE_OFF_BIT] : line_interrupt_disable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    next_rdata = 32'h00000000;
    if (cfg_rd_in) begin
      case (cfg_addr_in)
        hmc_pkg::COMMAND_OFFSET: begin
          next_rdata = {device_status_flags, command_control};
        end
        hmc_pkg::STEP_OFFSET: begin
          next_rdata = {device_class_code, stepping_code};
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the registered outputs
  always_comb begin
    next_ack = cfg_rd_in | cfg_wr_in;
    next_mmio_accept = mmio_req_in & memory_space_enable;
    next_mmio_refuse = mmio_req_in & ~memory_space_enable;
    // MSI follows bus mastering only, not the line disable
    next_msi = msi_req_in & bus_master_enable;
    next_line_irq = irq_sync & ~line_interrupt_disable;
    // Next enable, so DMA idles in the cycle of the clear
    next_dma_run = dma_req_in & next_bus_master;
    next_dma_idle = ~next_dma_run;
    // Window traffic to engine memory ignores bus mastering
    next_uma_req = window_req_in;
    next_mirror = command_control;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      bus_master_enable <= 1'b0;
      memory_space_enable <= 1'b0;
      line_interrupt_disable <= 1'b0;
      bus_master_prev <= 1'b0;
      cfg_rdata_out <= 32'h00000000;
      cfg_ack_out <= 1'b0;
      mmio_accept_out <= 1'b0;
      mmio_refuse_out <= 1'b0;
      msi_out <= 1'b0;
      line_irq_out <= 1'b0;
      dma_run_out <= 1'b0;
      dma_idle_out <= 1'b1;
      uma_req_out <= 1'b0;
      firmware_mirror_of_command_out <= 16'h0000;
    end else begin
      bus_master_enable <= next_bus_master;
      memory_space_enable <= next_mem_space;
      line_interrupt_disable <= next_line_irq_off;
      bus_master_prev <= bus_master_enable;
      cfg_rdata_out <= next_rdata;
      cfg_ack_out <= next_ack;
      mmio_accept_out <= next_mmio_accept;
      mmio_refuse_out <= next_mmio_refuse;
      msi_out <= next_msi;
      line_irq_out <= next_line_irq;
      dma_run_out <= next_dma_run;
      dma_idle_out <= next_dma_idle;
      uma_req_out <= next_uma_req;
      firmware_mirror_of_command_out <= next_mirror;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine message on a change of bus mastering
  assign bus_master_change = (bus_master_prev != bus_master_enable) &
    fw_bus_master_msg_en_in;

  hmc_engine_msg u_msg (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .event_in(bus_master_change),
    .ack_in(fw_msg_ack_in),
    .req_out(engine_msg_req_out)
  );
endmodule : hmc_cfg_header

// ### verilog/hmc_engine_msg.sv
`timescale 1ns/1ps
module hmc_engine_msg (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Event and handshake
  input wire logic event_in,
  input wire logic ack_in,
  output logic req_out
);
  hmc_pkg::hmc_msg_e state;
  hmc_pkg::hmc_msg_e next_state;
  logic pending;
  logic next_pending;
  logic next_req;

  always_comb begin
    next_state = state;
    next_pending = pending | event_in;
    case (state)
      hmc_pkg::HMC_MSG_IDLE: begin
        if (pending | event_in) begin
          next_state = hmc_pkg::HMC_MSG_SEND;
          next_pending = 1'b0;
        end
      end
      hmc_pkg::HMC_MSG_SEND: begin
        if (ack_in) begin
          next_state = hmc_pkg::HMC_MSG_WAIT;
        end
      end
      hmc_pkg::HMC_MSG_WAIT: begin
        next_state = hmc_pkg::HMC_MSG_IDLE;
      end
      default: begin
        next_state = hmc_pkg::HMC_MSG_IDLE;
      end
    endcase
    next_req = (next_state == hmc_pkg::HMC_MSG_SEND);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= hmc_pkg::HMC_MSG_IDLE;
      pending <= 1'b0;
      req_out <= 1'b0;
    end else begin
      state <= next_state;
      pending <= next_pending;
      req_out <= next_req;
    end
  end
endmodule : hmc_engine_msg

// ### verilog/hmc_pkg.sv
package hmc_pkg;
  // Configuration offsets, byte addressed
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [7:0] STEP_OFFSET = 8'h08;
  localparam logic [7:0] CLASS_OFFSET = 8'h09;
  // Command bit positions
  localparam int MEM_SPACE_BIT = 1;
  localparam int BUS_MASTER_BIT = 2;
  localparam int LINE_OFF_BIT = 10;
  // Status bit positions
  localparam int IRQ_STATUS_BIT = 3;
  localparam int CAP_LIST_BIT = 4;
  // Reset and hardwired values
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] COMMAND_WMASK = 16'h0406;
  localparam logic [15:0] STATUS_CONST = 16'h0010;
  localparam logic [23:0] CLASS_CODE = 24'h000000;
  // Arbitrary stepping value
  localparam logic [7:0] STEPPING = 8'h01;
  // Engine message state machine
  typedef enum logic [1:0] {
    HMC_MSG_IDLE = 2'b00,
    HMC_MSG_SEND = 2'b01,
    HMC_MSG_WAIT = 2'b10
  } hmc_msg_e;
endpackage : hmc_pkg

// ### verilog/hmc_sync.sv
`timescale 1ns/1ps
module hmc_sync (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Data
  input wire logic d_in,
  output logic q_out
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d_in;
    next_q = meta;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta <= next_meta;
      q_out <= next_q;
    end
  end
endmodule : hmc_sync
